// >>> brg_top.sv
// Serial bit-rate generator with receive-pin majority detector
`default_nettype none

// Summary of operation
// - Eight-bit free-running timer period set by divisor
// - Async low speed: rate is clock/(64(X+1))
// - Async high speed: rate is clock/(16(X+1))
// - Clocked mode: rate is clock/(4(X+1))
// - High speed select ignored in clocked mode
// - Ticks always in async mode, in clocked mode only when port is master
// - Divisor write restarts timer immediately
// - Receive pin sampled thrice, majority decides
// - Divisor is full unsigned range 0 to 255
// - High speed select is bit 2
// - Clocked mode select is bit 4
// - Clock source select chooses master or slave
module brg_top (
    input  wire logic                     clk_sys_i,
    input  wire logic                     sys_rst_i,
    input  wire brg_pkg::brg_bus_req_type bus_req_i,
    output logic [brg_pkg::DATA_W-1:0]    bus_rdata_o,
    input  wire logic                     shift_empty_i,
    input  wire logic [2:0]               rx_status_i,
    input  wire logic                     rx_pin_i,
    output logic                          bit_tick_o,
    output logic                          rx_level_o,
    output logic                          master_o,
    output logic                          clocked_mode_o,
    output logic                          high_speed_o
);

    // ==========================================================
    // State record
    typedef struct packed {
        logic [brg_pkg::TIMER_W-1:0] timer;
        logic [brg_pkg::PRE_W-1:0]   pre;
        logic                        tick;
        logic [1:0]                  samp;
        logic                        rx;
        logic [7:0]                  txsc;
        logic [7:0]                  rxsc;
        logic [7:0]                  div;
        logic [7:0]                  rdata;
    } brg_state_type;

    brg_state_type st_q;
    brg_state_type st_d;

    // ==========================================================
    // Helper functions

    // Expiries of the timer that make one bit
    function automatic logic [6:0] pre_len(input logic clocked,
                                           input logic high);
        logic [6:0] len;
        len = brg_pkg::PRE_LOW;
        if (clocked) begin
            len = brg_pkg::PRE_SYNC;
        end else if (high) begin
            len = brg_pkg::PRE_HIGH;
        end
        return len;
    endfunction

    // Majority of three samples
    function automatic logic vote3(input logic [2:0] s);
        return (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
    endfunction

    // ==========================================================
    // Decoded controls
    logic                      clocked;
    logic                      high;
    logic                      clock_source_select;
    logic                      enable;
    logic                      expiry;
    logic [6:0]                len;
    logic [brg_pkg::PRE_W-1:0] last;
    logic [brg_pkg::PRE_W-1:0] mid;
    logic                      div_wr;
    logic                      bit_end;

    // Mode fields and timer events
    always_comb begin
        clocked = st_q.txsc[brg_pkg::TXSC_CLOCKED_MODE_BIT];
        high    = st_q.txsc[brg_pkg::TXSC_HIGH_SPEED_BIT];
        clock_source_select    = st_q.txsc[brg_pkg::TXSC_CLOCK_SOURCE_BIT];
        // master in clocked mode only when source set
        // async always runs from own rate
        enable  = !clocked || clock_source_select;
        len     = pre_len(clocked, high);
        last    = brg_pkg::PRE_W'(len - 7'h01);
        mid     = brg_pkg::PRE_W'(len >> 1);
        div_wr  = bus_req_i.wr
                  && bus_req_i.addr == brg_pkg::OFF_BAUD_DIVISOR;
        expiry  = st_q.timer == '0;
        // Mode change mid-bit may leave count past the end: wrap too
        bit_end = expiry && st_q.pre >= last;
    end

    // ==========================================================
    // Next-state logic
    always_comb begin
        st_d      = st_q;
        st_d.tick = 1'b0;

        // timer counts down once per clock
        if (!expiry) begin
            st_d.timer = st_q.timer - 8'h01;
        end else begin
            // divisor taken as full unsigned value
            st_d.timer = st_q.div;
            if (bit_end) begin
                st_d.pre = '0;
            end else begin
                st_d.pre = st_q.pre + 6'h01;
            end
        end

        // one bit per len expiries, tick unless clocked slave
        if (bit_end) begin
            st_d.tick = enable;
        end

        // three samples around mid-bit, then vote
        if (expiry) begin
            if (st_q.pre == mid - 6'h01) begin
                st_d.samp[0] = rx_pin_i;
            end else if (st_q.pre == mid) begin
                st_d.samp[1] = rx_pin_i;
            end else if (st_q.pre == mid + 6'h01) begin
                st_d.rx = vote3({rx_pin_i, st_q.samp});
            end
        end

        // Register writes
        if (bus_req_i.wr) begin
            unique case (bus_req_i.addr)
                brg_pkg::OFF_TX_STATUS_CONTROL: begin
                    st_d.txsc = bus_req_i.wdata;
                end
                brg_pkg::OFF_RX_STATUS_CONTROL: begin
                    st_d.rxsc = bus_req_i.wdata;
                end
                brg_pkg::OFF_BAUD_DIVISOR: begin
                    st_d.div = bus_req_i.wdata;
                end
                default: begin
                end
            endcase
        end

        // divisor write restarts the timer and the bit count
        if (div_wr) begin
            st_d.timer = bus_req_i.wdata;
            st_d.pre   = '0;
            st_d.tick  = 1'b0;
        end

        // Register reads: data stand in the following cycle only
        st_d.rdata = '0;
        if (bus_req_i.rd) begin
            unique case (bus_req_i.addr)
                brg_pkg::OFF_TX_STATUS_CONTROL: begin
                    st_d.rdata = st_q.txsc;
                    st_d.rdata[brg_pkg::TXSC_UNUSED_BIT] = 1'b0;
                    st_d.rdata[brg_pkg::TXSC_SHIFT_EMPTY_BIT] =
                        shift_empty_i;
                end
                brg_pkg::OFF_RX_STATUS_CONTROL: begin
                    st_d.rdata = {st_q.rxsc[7:brg_pkg::RXSC_STATUS_W],
                                  rx_status_i};
                end
                brg_pkg::OFF_BAUD_DIVISOR: begin
                    st_d.rdata = st_q.div;
                end
                default: begin
                    st_d.rdata = '0;
                end
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            st_q       <= '0;
            st_q.txsc  <= brg_pkg::TXSC_RESET;
            st_q.rxsc  <= brg_pkg::RXSC_RESET;
            st_q.div   <= brg_pkg::DIV_RESET;
            st_q.timer <= brg_pkg::DIV_RESET;
            st_q.rx    <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Outputs
    assign bus_rdata_o    = st_q.rdata;
    assign bit_tick_o     = st_q.tick;
    assign rx_level_o     = st_q.rx;
    assign master_o       = clocked && clock_source_select;
    assign clocked_mode_o = clocked;
    assign high_speed_o   = high;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);

    chk_timer_down: assert property (
        !expiry && !div_wr |=> st_q.timer == $past(st_q.timer) - 8'h01)
        else $error("timer did not count down");

    chk_timer_reload: assert property (
        expiry && !div_wr && !bus_req_i.wr |=> st_q.timer == st_q.div)
        else $error("timer did not reload from divisor");

    chk_write_restart: assert property (
        div_wr |=> st_q.timer == $past(bus_req_i.wdata)
                   && st_q.pre == '0 && !bit_tick_o)
        else $error("divisor write did not restart timer");

    chk_low_len: assert property (
        expiry && !clocked && !high && st_q.pre == 6'h3f && !div_wr
        |=> bit_tick_o && st_q.pre == '0)
        else $error("low speed bit not 64 expiries");

    chk_high_len: assert property (
        expiry && !clocked && high && st_q.pre == 6'h0f && !div_wr
        |=> bit_tick_o && st_q.pre == '0)
        else $error("high speed bit not 16 expiries");

    chk_sync_len: assert property (
        expiry && clocked && clock_source_select && st_q.pre == 6'h03 && !div_wr
        |=> bit_tick_o)
        else $error("clocked bit not 4 expiries");

    // high speed has no effect in clocked mode
    chk_sync_hs_ignored: assert property (
        clocked && high && st_q.pre < 6'h03 |=> !bit_tick_o)
        else $error("high speed shortened clocked bit");

    chk_slave_quiet: assert property (
        clocked && !clock_source_select |=> !bit_tick_o)
        else $error("tick produced in slave mode");

    chk_majority: assert property (
        expiry && st_q.pre == mid + 6'h01 && !div_wr
        |=> rx_level_o == vote3({$past(rx_pin_i), $past(st_q.samp)}))
        else $error("receive level not majority of samples");

    // timer never above divisor when undisturbed
    chk_div_range: assert property (
        !bus_req_i.wr && st_q.timer <= st_q.div
        |=> st_q.timer <= st_q.div)
        else $error("timer left divisor range");

    chk_master_flag: assert property (
        bus_req_i.wr && bus_req_i.addr == brg_pkg::OFF_TX_STATUS_CONTROL
        && bus_req_i.wdata[7] && bus_req_i.wdata[4] |=> master_o)
        else $error("master flag not set by clock source");

    chk_tick_single: assert property (
        bit_tick_o |=> !bit_tick_o)
        else $error("bit tick longer than one cycle");

    // bit count moves only on expiry or divisor write
    chk_pre_hold: assert property (
        !expiry && !div_wr |=> $stable(st_q.pre))
        else $error("bit count moved without expiry");

    // final expiry wraps the bit count
    chk_pre_wrap: assert property (
        bit_end && !div_wr |=> st_q.pre == '0)
        else $error("bit count did not wrap at bit end");

    // level changes only at the vote
    chk_rx_hold: assert property (
        !(expiry && st_q.pre == mid + 6'h01) |=> $stable(rx_level_o))
        else $error("receive level changed outside the vote");

    // async ticks whatever the clock source
    chk_async_tick: assert property (
        !clocked && bit_end && !div_wr |=> bit_tick_o)
        else $error("asynchronous bit end gave no tick");

    // high speed keeps four expiries when clocked
    chk_sync_hs_len: assert property (
        expiry && clocked && clock_source_select && high && st_q.pre == 6'h03 && !div_wr
        |=> bit_tick_o)
        else $error("clocked high speed bit not 4 expiries");

    // high speed select read back at bit 2
    chk_read_hs_bit: assert property (
        bus_req_i.rd && bus_req_i.addr == brg_pkg::OFF_TX_STATUS_CONTROL
        |=> bus_rdata_o[brg_pkg::TXSC_HIGH_SPEED_BIT] == $past(high_speed_o))
        else $error("high speed select read back wrong");

    // clocked mode select read back at bit 4
    chk_read_sync_bit: assert property (
        bus_req_i.rd && bus_req_i.addr == brg_pkg::OFF_TX_STATUS_CONTROL
        |=> bus_rdata_o[brg_pkg::TXSC_CLOCKED_MODE_BIT]
            == $past(clocked_mode_o))
        else $error("clocked mode select read back wrong");

    chk_read_div: assert property (
        bus_req_i.rd && bus_req_i.addr == brg_pkg::OFF_BAUD_DIVISOR
        |=> bus_rdata_o == $past(st_q.div))
        else $error("divisor read back wrong");

    // slave count runs but stays silent
    chk_slave_wrap: assert property (
        clocked && !clock_source_select && bit_end && !div_wr
        |=> !bit_tick_o && st_q.pre == '0)
        else $error("slave bit end ticked or did not wrap");

    cov_low_tick: cover property (!clocked && !high && bit_tick_o);
    cov_high_tick: cover property (!clocked && high && bit_tick_o);
    cov_sync_tick: cover property (clocked && bit_tick_o);
    cov_restart: cover property (div_wr && st_q.timer != '0);
    cov_slave_end: cover property (clocked && !clock_source_select && bit_end);

endmodule

`default_nettype wire

// >>> brg_pkg.sv
// Package for the serial bit-rate generator: register map, fields, types
`default_nettype none

package brg_pkg;

    // ==========================================================
    // Register bus geometry
    localparam int unsigned ADDR_W = 2;
    localparam int unsigned DATA_W = 8;

    // ==========================================================
    // Register offsets
    localparam logic [1:0] OFF_TX_STATUS_CONTROL = 2'h0;
    localparam logic [1:0] OFF_RX_STATUS_CONTROL = 2'h1;
    localparam logic [1:0] OFF_BAUD_DIVISOR      = 2'h2;

    // ==========================================================
    // Field positions in tx_status_control
    localparam int unsigned TXSC_CLOCK_SOURCE_BIT = 7;
    localparam int unsigned TXSC_CLOCKED_MODE_BIT = 4;
    localparam int unsigned TXSC_UNUSED_BIT       = 3;
    localparam int unsigned TXSC_HIGH_SPEED_BIT   = 2;
    localparam int unsigned TXSC_SHIFT_EMPTY_BIT  = 1;

    // Status bits of rx_status_control below this position are read-only
    localparam int unsigned RXSC_STATUS_W = 3;

    // ==========================================================
    // Reset values
    localparam logic [7:0] TXSC_RESET = 8'h02;
    localparam logic [7:0] RXSC_RESET = 8'h00;
    localparam logic [7:0] DIV_RESET  = 8'h00;

    // ==========================================================
    // Timer width and prescale lengths in timer expiries per bit
    localparam int unsigned TIMER_W  = 8;
    localparam int unsigned PRE_W    = 6;
    localparam logic [6:0] PRE_LOW   = 7'h40;
    localparam logic [6:0] PRE_HIGH  = 7'h10;
    localparam logic [6:0] PRE_SYNC  = 7'h04;

    // ==========================================================
    // Register bus request carrier
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } brg_bus_req_type;

endpackage

`default_nettype wire

// >>> brg_shift_model.sv
// Far-side shift logic model: takes bit ticks, drives pin and status
`default_nettype none
module brg_shift_model (
    input  wire logic clk_sys_i,
    input  wire logic bit_tick_i,
    input  wire logic start_i,
    input  wire logic level_i,
    input  wire logic glitch_i,
    output logic      rx_pin_o,
    output logic      shift_empty_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] bits_q = 4'h0;
    logic [1:0] ph_q   = 2'h0;
    // Frame of ten bits, one per tick; phase counter for the pin dip
    always_ff @(posedge clk_sys_i) begin
        ph_q <= ph_q + 2'h1;
        if (start_i)
            bits_q <= 4'ha;
        else if (bit_tick_i && bits_q != 4'h0)
            bits_q <= bits_q - 4'h1;
    end
    assign shift_empty_o = (bits_q == 4'h0);
    // Steady level with a one-cycle inversion in every four cycles
    assign rx_pin_o = level_i ^ (glitch_i && ph_q == 2'h0);
endmodule
`default_nettype wire

// >>> test_serial_baud_rate_generator.sv
// Self-checking bench for the serial bit-rate generator
`default_nettype none
module test_serial_baud_rate_generator;
    timeunit 1ns;
    timeprecision 100ps;
    logic                     clk = 1'b0;
    logic                     rst = 1'b1;
    brg_pkg::brg_bus_req_type req = '0;
    logic [7:0]               rdata;
    logic [2:0]               rx_st = 3'h5;
    logic                     start = 1'b0;
    logic                     lvl = 1'b1;
    logic                     empty, pin, tick, rx_lvl, mst, clkd, hs;
    logic [7:0]               regs [4] = '{8'h02, 8'h00, 8'h00, 8'h00};
    logic [7:0]               modes [4] = '{8'h00, 8'h84, 8'h90, 8'h94};
    int                       nbit [4] = '{64, 16, 4, 4};
    int                       n_fail = 0;
    int                       cmp_count = 0;
    int                       seed = 32'h6f9e;
    int                       n, k, x;
    logic [7:0]               m;

    brg_top brg_top_i (
        .clk_sys_i      (clk),
        .sys_rst_i      (rst),
        .bus_req_i      (req),
        .bus_rdata_o    (rdata),
        .shift_empty_i  (empty),
        .rx_status_i    (rx_st),
        .rx_pin_i       (pin),
        .bit_tick_o     (tick),
        .rx_level_o     (rx_lvl),
        .master_o       (mst),
        .clocked_mode_o (clkd),
        .high_speed_o   (hs)
    );
    brg_shift_model brg_shift_model_i (
        .clk_sys_i     (clk),
        .bit_tick_i    (tick),
        .start_i       (start),
        .level_i       (lvl),
        .glitch_i      (1'b1),
        .rx_pin_o      (pin),
        .shift_empty_o (empty)
    );

    // ==========================================================
    // Clock, comparison and bus tasks
    always #2.5 clk = ~clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] expv(input logic [1:0] a);
        case (a)
            2'h0: return (regs[0] & 8'hf5) | {6'h00, empty, 1'b0};
            2'h1: return (regs[1] & 8'hf8) | {5'h00, rx_st};
            2'h2: return regs[2];
            default: return 8'h00;
        endcase
    endfunction

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        req <= '0;
        regs[a] = d;
    endtask

    task automatic rd(input logic [1:0] a);
        @(posedge clk);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        req <= '0;
        #1;
        check(16'(rdata), 16'(expv(a)));
    endtask

    // Edges from now until the next tick, bounded
    task automatic wait_tick(output int c);
        c = 0;
        do begin
            @(posedge clk);
            #1;
            c++;
        end while (tick !== 1'b1 && c < 20000);
    endtask

    task automatic end_of_test;
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        // Reset values, then unmapped and read-only places
        for (int a = 0; a < 4; a++)
            rd(2'(a));
        wr(2'h3, 8'hff);
        rx_st <= 3'($random(seed));
        wr(2'h1, 8'hff);
        for (int a = 0; a < 4; a++)
            rd(2'(a));
        // Every mode; restart from a long count to a short one
        foreach (modes[i]) begin
            x = $random(seed) & 7;
            m = modes[i] | (8'($random(seed)) & 8'h61);
            wr(2'h0, m);
            #1;
            check(16'({mst, clkd, hs}),
                  16'({m[7] & m[4], m[4], m[2]}));
            wr(2'h2, 8'hff);
            repeat (x) @(posedge clk);
            wr(2'h2, 8'(x));
            wait_tick(n);
            check(16'(n), 16'(nbit[i] * (x + 1)));
            wait_tick(n);
            check(16'(n), 16'(nbit[i] * (x + 1)));
            rd(2'h0);
        end
        // high speed kept at the slowest divisor
        wr(2'h0, 8'h04);
        wr(2'h2, 8'hff);
        wait_tick(n);
        check(16'(n), 16'h1000);
        // Clocked slave: no ticks
        wr(2'h0, 8'h10);
        wr(2'h2, 8'h00);
        k = 0;
        repeat (300) begin
            @(posedge clk);
            #1;
            if (tick !== 1'b0)
                k++;
        end
        check(16'(k), 16'h0000);
        // Master frame busy flag and majority vote against dips
        wr(2'h0, 8'h90);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        rd(2'h0);
        @(posedge clk);
        lvl <= 1'b0;
        repeat (16) @(posedge clk);
        #1;
        check(16'(rx_lvl), 16'h0000);
        @(posedge clk);
        lvl <= 1'b1;
        repeat (16) @(posedge clk);
        #1;
        check(16'(rx_lvl), 16'h0001);
        // Reset in mid-run with the pin low: defaults come back
        @(posedge clk);
        lvl <= 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        regs = '{8'h02, 8'h00, 8'h00, 8'h00};
        #1;
        check(16'(rx_lvl), 16'h0001);
        check(16'({tick, mst, rdata}), 16'h0000);
        for (int a = 0; a < 4; a++)
            rd(2'(a));
        end_of_test();
    end

    // Watchdog well beyond the expected run
    initial begin
        #400000;
        n_fail++;
        end_of_test();
    end
endmodule
`default_nettype wire
